// ### verilog/dac_pkg.sv
// How it works
// - Two 8-bit read/write channel data registers
// - Data registers clear on reset and standby
// - Enabled channel data presented continuously
// - Control register loads 0x1f on reset/standby
// - Bit 7 enables channel 1 conversion, drive
// - Bit 6 enables channel 0 conversion, drive
// - Bit 5 joins both channels' conversion
// - Conversion enable truth table per channel
// - Pin drive follows own enable only
// - Control bits 4..0 ignore writes, read ones
// - Three registers decoded from 0xfff8 upward
// - New data converts at once, no trigger
// - Cleared enable releases channel 0 pin
package dac_pkg;
    localparam int addr_width = 16; // Byte address bus width
    localparam int data_width = 8; // Register width
    localparam logic [15:0] addr_data_ch0 = 16'hfff8; // Channel 0 data
    localparam logic [15:0] addr_data_ch1 = 16'hfff9; // Channel 1 data
    localparam logic [15:0] addr_control = 16'hfffa; // Control
    localparam logic [7:0] data_reset = 8'h00; // Data reset value
    localparam logic [7:0] control_reset = 8'h1f; // Control reset value
    localparam logic [7:0] control_reserved = 8'h1f; // Bits that read as one
    localparam int bit_out_enable_ch1 = 7; // Channel 1 output enable
    localparam int bit_out_enable_ch0 = 6; // Channel 0 output enable
    localparam int bit_joint_conv_enable = 5; // Joint enable
    localparam logic [7:0] unmapped_read = 8'h00; // Answer for foreign addresses

    // Per-channel signals towards the analog macro
    typedef struct packed {
        logic conv_enable;
        logic drive_enable;
        logic [7:0] data;
    } dac_channel_type;
endpackage

// ### verilog/dac_channel_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// One channel's registered outputs to the analog macro
module dac_channel_ctrl
    import dac_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic standby_i, // Forces the channel idle
    input wire logic own_enable_i, // This channel's output enable
    input wire logic other_enable_i, // The other channel's output enable
    input wire logic joint_i, // Joint conversion enable
    input wire logic [7:0] data_i, // Data register contents
    output var dac_channel_type chan_o // Registered macro signals
);
    // Conversion: own enable, or other enable with joint set
    wire logic next_conv = own_enable_i | (other_enable_i & joint_i);
    wire dac_channel_type next_chan = '{
        conv_enable: next_conv,
        drive_enable: own_enable_i,
        data: data_i
    };

    // Registered outputs, idle under reset and standby
    always_ff @(posedge clk_i) begin
        if (!rstn_i || standby_i) begin
            chan_o <= '{conv_enable: 1'b0, drive_enable: 1'b0, data: data_reset};
        end else begin
            chan_o <= next_chan;
        end
    end
endmodule
`default_nettype wire

// ### verilog/dual_channel_dac_control.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Register file and enable logic for the two-channel converter
module dual_channel_dac_control
    import dac_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic standby_i, // High while the chip sits in standby
    input wire logic [15:0] addr_i, // Register byte address
    input wire logic [7:0] wdata_i, // Write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    output logic [7:0] rdata_o, // Read data, cycle after strobe
    output var dac_channel_type analog_out_ch0_o, // Channel 0 macro signals
    output var dac_channel_type analog_out_ch1_o // Channel 1 macro signals
);
    logic [7:0] dac_data_ch0; // Channel 0 data
    logic [7:0] dac_data_ch1; // Channel 1 data
    logic [2:0] control_bits; // Writable control bits 7..5

    // Address decode
    wire logic hit_ch0 = (addr_i == addr_data_ch0);
    wire logic hit_ch1 = (addr_i == addr_data_ch1);
    wire logic hit_ctl = (addr_i == addr_control);

    // Assembled control view; reserved bits always one
    wire logic [7:0] dac_control = {control_bits, control_reserved[4:0]};

    wire logic out_enable_ch1 = dac_control[bit_out_enable_ch1];
    wire logic out_enable_ch0 = dac_control[bit_out_enable_ch0];
    wire logic joint_conv_enable = dac_control[bit_joint_conv_enable];

    // Read mux; unmapped addresses read zero
    wire logic [7:0] next_rdata =
        hit_ch0 ? dac_data_ch0 :
        hit_ch1 ? dac_data_ch1 :
        hit_ctl ? dac_control : unmapped_read;

    // Data registers; standby clears like reset
    always_ff @(posedge clk_i) begin
        if (!rstn_i || standby_i) begin
            dac_data_ch0 <= data_reset;
            dac_data_ch1 <= data_reset;
        end else if (wr_i) begin
            if (hit_ch0) begin
                dac_data_ch0 <= wdata_i;
            end
            if (hit_ch1) begin
                dac_data_ch1 <= wdata_i;
            end
        end
    end

    // Control register; only bits 7..5 take writes
    always_ff @(posedge clk_i) begin
        if (!rstn_i || standby_i) begin
            control_bits <= control_reset[7:5];
        end else if (wr_i && hit_ctl) begin
            control_bits <= wdata_i[7:5];
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            rdata_o <= next_rdata;
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // Channel 0 macro signals
    dac_channel_ctrl u_ch0 (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .standby_i(standby_i),
        .own_enable_i(out_enable_ch0),
        .other_enable_i(out_enable_ch1),
        .joint_i(joint_conv_enable),
        .data_i(dac_data_ch0),
        .chan_o(analog_out_ch0_o)
    );

    // Channel 1 macro signals
    dac_channel_ctrl u_ch1 (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .standby_i(standby_i),
        .own_enable_i(out_enable_ch1),
        .other_enable_i(out_enable_ch0),
        .joint_i(joint_conv_enable),
        .data_i(dac_data_ch1),
        .chan_o(analog_out_ch1_o)
    );
endmodule
`default_nettype wire

// ### test/dac_ctl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Port checks; outputs lag a write by two edges
module dac_ctl_asserts
    import dac_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic standby_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire dac_channel_type analog_out_ch0_o,
    input wire dac_channel_type analog_out_ch1_o
);
    logic [7:0] w1, w2; // Write data, delayed to meet the output lag
    always_ff @(posedge clk_i) {w2, w1} <= {w1, wdata_i};
    wire dac_channel_type o0 = analog_out_ch0_o, o1 = analog_out_ch1_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // Write that standby does not cancel before it lands
    sequence s_w(x); wr_i && addr_i == x && !standby_i ##1 !standby_i; endsequence
    property p_d0; s_w(addr_control) |=> o0.drive_enable == w2[6]; endproperty
    a_d0: assert property (p_d0) else $error("ch0 drive wrong");
    property p_d1; s_w(addr_control) |=> o1.drive_enable == w2[7]; endproperty
    a_d1: assert property (p_d1) else $error("ch1 drive wrong");
    property p_c0; s_w(addr_control) |=> o0.conv_enable == (w2[6] | w2[7] & w2[5]); endproperty
    a_c0: assert property (p_c0) else $error("ch0 conv wrong");
    property p_c1; s_w(addr_control) |=> o1.conv_enable == (w2[7] | w2[6] & w2[5]); endproperty
    a_c1: assert property (p_c1) else $error("ch1 conv wrong");
    property p_dt; s_w(addr_data_ch0) |=> o0.data == w2; endproperty
    a_dt: assert property (p_dt) else $error("ch0 data wrong");
    property p_dt1; s_w(addr_data_ch1) |=> o1.data == w2; endproperty
    a_dt1: assert property (p_dt1) else $error("ch1 data wrong");
    property p_rc; rd_i && addr_i == addr_control && !standby_i |=> rdata_o[4:0] == 5'h1f; endproperty
    a_rc: assert property (p_rc) else $error("reserved bits wrong");
    property p_rz; !rd_i || addr_i > addr_control || addr_i < addr_data_ch0 |=> rdata_o == 8'h00; endproperty
    a_rz: assert property (p_rz) else $error("stray read data");
    property p_rs; disable iff (1'h0) !rstn_i || standby_i |=> o0 == 10'h0 && o1 == 10'h0; endproperty
    a_rs: assert property (p_rs) else $error("outputs not idle");
endmodule
bind dual_channel_dac_control dac_ctl_asserts i_dac_ctl_asserts (.*);
`default_nettype wire

// ### test/dac_macro_model.sv
`timescale 1ns/1ps
`default_nettype none
// Analog macro stand-in for one channel
module dac_macro_model
    import dac_pkg::*;
(
    input wire logic clk_i,
    input wire dac_channel_type chan_i,
    output logic [7:0] pin_o
);
    logic [7:0] held; // Last converted code
    always_ff @(posedge clk_i) if (chan_i.conv_enable) held <= chan_i.data;
    // Released pin shows the inverse, never a stale level
    assign pin_o = chan_i.drive_enable ? held : ~held;
endmodule
`default_nettype wire

// ### test/dual_channel_dac_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dual_channel_dac_control_bench;
    import dac_pkg::*;
    logic clk_i = 1'h0, rstn_i = 1'h0, standby_i = 1'h0, wr_i = 1'h0, rd_i = 1'h0;
    logic [15:0] addr_i = 16'h0;
    logic [7:0] wdata_i = 8'h0, rdata_o, pin;
    dac_channel_type analog_out_ch0_o, analog_out_ch1_o;
    int num_errors = 0, n_tests = 0;
    dual_channel_dac_control i_dual_channel_dac_control (.*);
    dac_macro_model i_dac_macro_model (.clk_i, .chan_i(analog_out_ch0_o), .pin_o(pin));
    initial forever #12.5 clk_i = ~clk_i;
    task chk(input logic [7:0] s, e);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH %0t %h %h", $time, s, e);
        end
    endtask
    // Op 2 writes, op 1 reads and checks the cycle after
    task acc(input logic [1:0] op, input logic [15:0] a, input logic [7:0] d);
        {wr_i, rd_i, addr_i, wdata_i} <= {op, a, d};
        @(posedge clk_i);
        if (op[0]) begin
            rd_i <= 1'h0;
            @(negedge clk_i) chk(rdata_o, d);
            @(posedge clk_i);
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rstn_i <= 1'h1;
        acc(2'h1, 16'hfff8, 8'h00);
        acc(2'h1, 16'hfffa, 8'h1f);
        for (int k = 0; k < 8; k++) begin
            acc(2'h2, 16'hfffa, {k[2:0], 5'h0a});
            acc(2'h1, 16'hfffa, {k[2:0], 5'h1f});
        end
        $display("control test done");
        acc(2'h2, 16'hfff8, 8'ha5);
        acc(2'h2, 16'hfff9, 8'h3c);
        acc(2'h1, 16'hfff8, 8'ha5);
        acc(2'h1, 16'hfff9, 8'h3c);
        chk(pin, 8'ha5);
        chk(analog_out_ch1_o.data, 8'h3c);
        acc(2'h2, 16'hfffb, 8'hff);
        acc(2'h1, 16'hfffb, 8'h00);
        standby_i <= 1'h1;
        @(posedge clk_i);
        standby_i <= 1'h0;
        acc(2'h1, 16'hfff9, 8'h00);
        chk(pin, 8'h5a);
        $display("data test done");
        conclude();
    end
    // Hang guard, well past the planned run
    initial begin
        repeat (400) @(posedge clk_i);
        num_errors++;
        conclude();
    end
endmodule
`default_nettype wire
